/* verilog/ausc_pkg.sv */
package ausc_pkg;

  // APB geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_MODE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_MASK = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_RXDATA = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_TXLEFT = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_TXRIGHT = 12'h018;

  // Control register layout
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_0001;

  // Mode register layout
  localparam int unsigned FIELD_W = 6;
  localparam int unsigned MODE_RATIO_LSB = 24;
  localparam int unsigned MODE_DIV_LSB = 16;
  localparam int unsigned MODE_GEN_BIT = 30;
  localparam int unsigned MODE_REPEAT_BIT = 14;
  localparam int unsigned MODE_DMA_BIT = 13;
  localparam int unsigned MODE_MONO_BIT = 12;
  localparam int unsigned MODE_LOOP_BIT = 10;
  localparam logic [DATA_W-1:0] MODE_RESET = 32'h0000_0000;
  // Divider bits are stored but never read back
  localparam logic [DATA_W-1:0] MODE_WRITE_MASK = 32'hff3f_77dd;
  localparam logic [DATA_W-1:0] MODE_READ_MASK = 32'hff00_77dd;

  // Event bits of status and mask registers
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_UNDERRUN = 0;
  localparam int unsigned EVT_RXRDY = 1;
  localparam int unsigned EVT_OVERRUN = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

  // Frame: two slots of sixteen bits, MSB first
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned BIT_IDX_W = 5;
  localparam logic [BIT_IDX_W-1:0] LEFT_LAST = 5'h0f;
  localparam logic [BIT_IDX_W-1:0] RIGHT_LAST = 5'h1f;
  localparam logic [SAMPLE_W-1:0] ZERO_SAMPLE = 16'h0000;
  localparam int unsigned FRAME_SHIFT = 5;

endpackage : ausc_pkg

/* verilog/ausc_divider.sv */
`timescale 1ns/1ns

// Free counter that wraps after limit+1 clocks; clear parks it on its last step,
// so the first period after a start begins at once with no dummy clock
module ausc_divider (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Control
  input wire logic clear,
  input wire logic [5:0] limit,
  // Timing
  output logic tick,
  output logic high
);

  // Position inside the period
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  // Half period, rounded down, so an odd ratio is slightly low-heavy
  logic [6:0] half;

  assign tick = (cnt_reg == limit);
  assign half = ({1'b0, limit} + 7'h01) >> 1;
  assign high = ({1'b0, cnt_reg} < half);
  assign cnt_next = clear ? limit : (tick ? 6'h00 : cnt_reg + 6'h01);

  // Counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : ausc_divider

/* verilog/ausc_mode_ctrl.sv */
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns

// How it works
// R1 - Master clock equals sample rate times ratio/divider
// R2 - Ratio field bits 29:24, ratio 32*(v+1)
// R3 - Master clock is clock divided by divider+1
// R4 - Divider field reads back as zero
// R5 - Software never writes divider zero
// R6 - Underrun sends zero or repeats previous sample
// R7 - One or per-channel transmit DMA requests
// R8 - Mono copies left sample onto right
// R9 - Loopback routes data out to data in
// R10 - Master clock output only when generation enabled
// R11 - Software changes mode only while stopped
module ausc_mode_ctrl
  import ausc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  output logic master_clock_out,
  output logic serial_clock_out,
  output logic word_select,
  output logic serial_data_out,
  input wire logic serial_data_in,
  // DMA requests and interrupt
  output logic tx_dma_req0,
  output logic tx_dma_req1,
  output logic irq
);

  // Register state
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] audio_mode_config_reg;
  logic [EVT_W-1:0] status_reg;
  logic [EVT_W-1:0] mask_reg;
  logic [SAMPLE_W-1:0] rx_data_reg;
  // Transmit holding words and their fill flags
  logic [SAMPLE_W-1:0] tx_left_reg;
  logic [SAMPLE_W-1:0] tx_right_reg;
  logic tx_left_v_reg;
  logic tx_right_v_reg;
  // Last samples sent, kept for the repeat policy
  logic [SAMPLE_W-1:0] prev_left_reg;
  logic [SAMPLE_W-1:0] prev_right_reg;
  // Frame engine
  logic [BIT_IDX_W-1:0] bit_idx_reg;
  logic [SAMPLE_W-1:0] tx_shift_reg;
  logic [SAMPLE_W-1:0] rx_shift_reg;
  // Low until the first boundary, which closes no received slot
  logic rx_live_reg;
  // Bus answer flops
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  // Pin flops
  logic mclk_reg;
  logic sck_reg;
  logic ws_reg;
  logic sdo_reg;
  logic req0_reg;
  logic req1_reg;
  logic irq_reg;

  // Mode fields
  logic en;
  logic [5:0] mclk_to_fs_ratio_sel;
  logic [5:0] mclk_divider;
  logic mclk_generate_en;
  logic underrun_repeat_sel;
  logic tx_dma_per_channel;
  logic tx_mono_sel;
  logic internal_loopback_sel;
  assign en = ctrl_reg[CTRL_EN_BIT];
  assign mclk_to_fs_ratio_sel = audio_mode_config_reg[MODE_RATIO_LSB +: FIELD_W];
  assign mclk_divider = audio_mode_config_reg[MODE_DIV_LSB +: FIELD_W];
  assign mclk_generate_en = audio_mode_config_reg[MODE_GEN_BIT];
  assign underrun_repeat_sel = audio_mode_config_reg[MODE_REPEAT_BIT];
  assign tx_dma_per_channel = audio_mode_config_reg[MODE_DMA_BIT];
  assign tx_mono_sel = audio_mode_config_reg[MODE_MONO_BIT];
  assign internal_loopback_sel = audio_mode_config_reg[MODE_LOOP_BIT];

  // Bus decode: setup cycle prepares the answer, access cycle commits
  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic hit_any;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_status;
  logic wr_mask;
  logic wr_left;
  logic wr_right;
  logic rd_rx;
  logic [DATA_W-1:0] rd_mux;
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pready_reg && pwrite;
  assign acc_rd = psel && penable && pready_reg && !pwrite;
  assign hit_any = (paddr == OFF_CTRL) || (paddr == OFF_MODE) || (paddr == OFF_STATUS)
    || (paddr == OFF_MASK) || (paddr == OFF_RXDATA) || (paddr == OFF_TXLEFT)
    || (paddr == OFF_TXRIGHT);
  assign wr_ctrl = acc_wr && (paddr == OFF_CTRL);
  assign wr_mode = acc_wr && (paddr == OFF_MODE);
  assign wr_status = acc_wr && (paddr == OFF_STATUS);
  assign wr_mask = acc_wr && (paddr == OFF_MASK);
  assign wr_left = acc_wr && (paddr == OFF_TXLEFT);
  assign wr_right = acc_wr && (paddr == OFF_TXRIGHT);
  assign rd_rx = acc_rd && (paddr == OFF_RXDATA);
  // R4 divider hidden on read
  assign rd_mux = (paddr == OFF_CTRL) ? ctrl_reg :
    (paddr == OFF_MODE) ? (audio_mode_config_reg & MODE_READ_MASK) :
    (paddr == OFF_STATUS) ? {{(DATA_W-EVT_W){1'b0}}, status_reg} :
    (paddr == OFF_MASK) ? {{(DATA_W-EVT_W){1'b0}}, mask_reg} :
    (paddr == OFF_RXDATA) ? {{(DATA_W-SAMPLE_W){1'b0}}, rx_data_reg} :
    (paddr == OFF_TXLEFT) ? {{(DATA_W-SAMPLE_W){1'b0}}, tx_left_reg} :
    (paddr == OFF_TXRIGHT) ? {{(DATA_W-SAMPLE_W){1'b0}}, tx_right_reg} : '0;

  // Timing sources; both park on their last step while the controller is off
  logic mclk_tick;
  logic mclk_high;
  logic bit_tick;
  logic bit_high;
  // R3 divide by divider plus one
  ausc_divider u_mclk_div (
    .clock(clock),
    .rstn(rstn),
    .clear(!en),
    .limit(mclk_divider),
    .tick(mclk_tick),
    .high(mclk_high)
  );
  // R2 bit period is ratio plus one clocks, 32 bits a frame
  ausc_divider u_bit_div (
    .clock(clock),
    .rstn(rstn),
    .clear(!en),
    .limit(mclk_to_fs_ratio_sel),
    .tick(bit_tick),
    .high(bit_high)
  );

  // Slot boundaries
  logic load_left;
  logic load_right;
  logic slot_end;
  logic rx_bit;
  logic [SAMPLE_W-1:0] rx_word;
  assign load_left = en && bit_tick && (bit_idx_reg == RIGHT_LAST);
  assign load_right = en && bit_tick && (bit_idx_reg == LEFT_LAST);
  assign slot_end = load_left || load_right;
  // R9 loopback mux on the receive path
  assign rx_bit = internal_loopback_sel ? sdo_reg : serial_data_in;
  assign rx_word = {rx_shift_reg[SAMPLE_W-2:0], rx_bit};

  // R6 underrun policy picks zero or previous sample
  logic [SAMPLE_W-1:0] left_pick;
  logic [SAMPLE_W-1:0] right_pick;
  logic under_left;
  logic under_right;
  assign under_left = load_left && !tx_left_v_reg;
  assign under_right = load_right && !tx_mono_sel && !tx_right_v_reg;
  assign left_pick = tx_left_v_reg ? tx_left_reg :
    (underrun_repeat_sel ? prev_left_reg : ZERO_SAMPLE);
  // R8 mono repeats the left sample just sent
  assign right_pick = tx_mono_sel ? prev_left_reg : tx_right_v_reg ? tx_right_reg :
    (underrun_repeat_sel ? prev_right_reg : ZERO_SAMPLE);

  // Next shift word and events
  logic [SAMPLE_W-1:0] shift_next;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] status_next;
  assign shift_next = load_left ? left_pick : load_right ? right_pick :
    {tx_shift_reg[SAMPLE_W-2:0], 1'b0};
  assign evt[EVT_UNDERRUN] = under_left || under_right;
  assign evt[EVT_RXRDY] = slot_end && rx_live_reg;
  assign evt[EVT_OVERRUN] = slot_end && rx_live_reg && status_reg[EVT_RXRDY];
  // Write one to clear; a new event in the same cycle wins
  assign status_next = (status_reg & ~(wr_status ? pwdata[EVT_W-1:0] : '0)) | evt;

  // R7 request lines by DMA mode
  logic req0_next;
  logic req1_next;
  assign req0_next = en && (tx_dma_per_channel ? !tx_left_v_reg :
    (!tx_left_v_reg || (!tx_mono_sel && !tx_right_v_reg)));
  assign req1_next = en && tx_dma_per_channel && !tx_mono_sel && !tx_right_v_reg;

  // Bus answer: zero wait states, error on unmapped offsets
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= (setup && !pwrite) ? rd_mux : '0;
      pready_reg <= setup;
      pslverr_reg <= setup && !hit_any;
    end
  end

  // Software registers; R11 mode is trusted to change only while stopped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= '0;
      audio_mode_config_reg <= MODE_RESET;
      mask_reg <= EVT_RESET;
      status_reg <= EVT_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata & CTRL_MASK;
      end
      // R5 divider zero is not guarded here
      if (wr_mode) begin
        audio_mode_config_reg <= pwdata & MODE_WRITE_MASK;
      end
      if (wr_mask) begin
        mask_reg <= pwdata[EVT_W-1:0];
      end
      status_reg <= status_next;
    end
  end

  // Transmit holding words; a write sets the flag even as a slot consumes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_left_reg <= ZERO_SAMPLE;
      tx_right_reg <= ZERO_SAMPLE;
      tx_left_v_reg <= 1'b0;
      tx_right_v_reg <= 1'b0;
    end else begin
      if (wr_left) begin
        tx_left_reg <= pwdata[SAMPLE_W-1:0];
      end
      if (wr_right) begin
        tx_right_reg <= pwdata[SAMPLE_W-1:0];
      end
      tx_left_v_reg <= wr_left || (tx_left_v_reg && !load_left);
      tx_right_v_reg <= wr_right || (tx_right_v_reg && !(load_right && !tx_mono_sel));
    end
  end

  // Frame engine: shift on every bit tick, reload at slot ends
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_idx_reg <= RIGHT_LAST;
      tx_shift_reg <= ZERO_SAMPLE;
      rx_shift_reg <= ZERO_SAMPLE;
      rx_data_reg <= ZERO_SAMPLE;
      prev_left_reg <= ZERO_SAMPLE;
      prev_right_reg <= ZERO_SAMPLE;
      rx_live_reg <= 1'b0;
    end else if (!en) begin
      // Stopped: next start begins with the left slot
      bit_idx_reg <= RIGHT_LAST;
      rx_live_reg <= 1'b0;
    end else if (bit_tick) begin
      bit_idx_reg <= bit_idx_reg + 5'h01;
      tx_shift_reg <= shift_next;
      rx_shift_reg <= rx_word;
      rx_live_reg <= 1'b1;
      if (slot_end && rx_live_reg) begin
        rx_data_reg <= rx_word;
      end
      if (load_left) begin
        prev_left_reg <= left_pick;
      end
      if (load_right) begin
        prev_right_reg <= right_pick;
      end
    end
  end

  // Pins and request lines, all from flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mclk_reg <= 1'b0;
      sck_reg <= 1'b0;
      ws_reg <= 1'b0;
      sdo_reg <= 1'b0;
      req0_reg <= 1'b0;
      req1_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      // R10 master clock only in generate mode
      mclk_reg <= en && mclk_generate_en && mclk_high;
      // Rises one clock into each bit at ratio 1 or more (stays low at ratio 0), so the far side samples settled data
      sck_reg <= en && bit_high;
      if (!en) begin
        // Stopped: the link rests low
        ws_reg <= 1'b0;
        sdo_reg <= 1'b0;
      end else if (bit_tick) begin
        ws_reg <= load_right || (!load_left && ws_reg);
        sdo_reg <= shift_next[SAMPLE_W-1];
      end
      req0_reg <= req0_next;
      req1_reg <= req1_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign master_clock_out = mclk_reg;
  assign serial_clock_out = sck_reg;
  assign word_select = ws_reg;
  assign serial_data_out = sdo_reg;
  assign tx_dma_req0 = req0_reg;
  assign tx_dma_req1 = req1_reg;
  assign irq = irq_reg;

  // Checking helpers: cycles between master ticks and between frame starts
  logic [6:0] mclk_gap;
  logic mclk_seen;
  logic [11:0] fs_gap;
  logic fs_seen;
  logic ws_prev;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mclk_gap <= 7'h00;
      mclk_seen <= 1'b0;
      fs_gap <= 12'h000;
      fs_seen <= 1'b0;
      ws_prev <= 1'b0;
    end else begin
      ws_prev <= ws_reg;
      mclk_gap <= mclk_tick ? 7'h01 : mclk_gap + 7'h01;
      mclk_seen <= en && (mclk_seen || mclk_tick);
      fs_gap <= (ws_reg && !ws_prev) ? 12'h001 : fs_gap + 12'h001;
      fs_seen <= en && (fs_seen || (ws_reg && !ws_prev));
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // R1 frame period
  a_frame_period: assert property (en && fs_seen && ws_reg && !ws_prev
    |-> fs_gap == ((12'({6'h00, mclk_to_fs_ratio_sel}) + 12'h001) << FRAME_SHIFT)) // R1
    else $error("word select period does not match ratio");
  // R2 bit period
  a_bit_ratio: assert property (en && bit_tick && $past(en)
    |=> !en || ((mclk_to_fs_ratio_sel == 6'h00) == bit_tick)) // R2
    else $error("bit tick spacing wrong for ratio");
  // R3 divider period
  a_mclk_divide: assert property (en && mclk_seen && mclk_tick
    |-> mclk_gap == ({1'b0, mclk_divider} + 7'h01)) // R3
    else $error("master clock period not divider plus one");
  // R4 read zero
  a_div_read_zero: assert property (acc_rd && paddr == OFF_MODE
    |-> prdata[MODE_DIV_LSB +: FIELD_W] == 6'h00) // R4
    else $error("divider field read back nonzero");
  // R6 zero fill
  a_under_zero: assert property (under_left && !underrun_repeat_sel
    |=> tx_shift_reg == ZERO_SAMPLE ##0 serial_data_out == 1'b0) // R6
    else $error("underrun did not send zero");
  a_under_repeat: assert property (under_left && underrun_repeat_sel
    |=> tx_shift_reg == $past(prev_left_reg)) // R6
    else $error("underrun did not repeat sample");
  // R7 request routing
  a_dma_single: assert property (!tx_dma_per_channel |=> !tx_dma_req1) // R7
    else $error("second request in single channel mode");
  // R8 mono copy
  a_mono_copy: assert property (load_right && tx_mono_sel
    |=> tx_shift_reg == prev_left_reg ##0 !tx_dma_req1) // R8
    else $error("mono right slot not a left copy");
  // R9 loopback
  a_loop_route: assert property (en && bit_tick && internal_loopback_sel
    |=> rx_shift_reg[0] == $past(serial_data_out)) // R9
    else $error("loopback did not capture data out");
  // R10 master clock off
  a_mclk_off: assert property (!mclk_generate_en |=> !master_clock_out) // R10
    else $error("master clock driven while not generated");

  c_underrun: cover property (under_left ##1 irq);
  c_mono: cover property (tx_mono_sel && load_right);
  c_loop_rx: cover property (internal_loopback_sel && slot_end);
  c_per_chan: cover property (tx_dma_req0 && tx_dma_req1);

endmodule : ausc_mode_ctrl

/* bench/ausc_codec_model.sv */
`timescale 1ns/1ns

// Codec stand-in: collects each 16-bit slot and answers with inverted data
module ausc_codec_model (
  // Clock and control
  input wire logic clock,
  input wire logic clear,
  // Serial link
  input wire logic serial_clock_out,
  input wire logic word_select,
  input wire logic serial_data_out,
  output logic serial_data_in
);
  logic sck_d = 1'b0; // Bit clock at previous look
  logic ws_d; // Slot of previous bit
  logic [15:0] sh = 16'h0000; // Incoming bits, MSB first
  int cnt = 0; // Bits gathered in this slot
  int frames = 0; // Completed frames
  logic [15:0] lw [0:7]; // Left word per frame
  logic [15:0] rw [0:7]; // Right word per frame

  // Inverse of the line, so a missing internal loop cannot look right
  assign serial_data_in = ~serial_data_out;

  // Look between system edges, where the bit clock and data are settled;
  // the high phase belongs to one bit whichever edge the design launches on
  always @(negedge clock) begin
    if (clear) begin
      cnt = 0;
      frames = 0;
    end else if (serial_clock_out && !sck_d) begin
      // A new slot restarts the count
      if (word_select !== ws_d) begin
        cnt = 0;
      end
      ws_d = word_select;
      sh = {sh[14:0], serial_data_out};
      cnt = cnt + 1;
      if (cnt == 16 && word_select) begin
        rw[frames % 8] = sh;
        frames = frames + 1;
        cnt = 0;
      end else if (cnt == 16) begin
        lw[frames % 8] = sh;
        cnt = 0;
      end
    end
    sck_d = serial_clock_out;
  end
endmodule : ausc_codec_model

/* bench/i2s_mode_clock_and_tx_options_tb_top.sv */
`timescale 1ns/1ns

module i2s_mode_clock_and_tx_options_tb_top;
  import ausc_pkg::*;
  // Clock, reset and bus drive
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic codec_clear = 1'b1;
  // Design outputs
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, irq, tx_dma_req0, tx_dma_req1;
  logic master_clock_out, serial_clock_out, word_select, serial_data_out, serial_data_in;
  // Bookkeeping
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [DATA_W-1:0] rd;
  logic rd_err;
  logic [15:0] lexp;
  // Scenario tables: ratio, divider, generate; then repeat, dma, mono
  logic [5:0] rt [4] = '{6'h01, 6'h03, 6'h02, 6'h00};
  logic [5:0] dt [4] = '{6'h02, 6'h04, 6'h01, 6'h02};
  logic gt [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic rp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic dm [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic mo [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  // Period meters
  logic mck_d = 1'b0;
  logic ws_d = 1'b0;
  int mck_cnt = 0, ws_cnt = 0, mck_per = 0, ws_per = 0;

  always #4 clock = ~clock;

  ausc_mode_ctrl i_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_clock_out(master_clock_out),
    .serial_clock_out(serial_clock_out), .word_select(word_select),
    .serial_data_out(serial_data_out), .serial_data_in(serial_data_in),
    .tx_dma_req0(tx_dma_req0), .tx_dma_req1(tx_dma_req1), .irq(irq));

  ausc_codec_model i_codec (.clock(clock), .clear(codec_clear),
    .serial_clock_out(serial_clock_out), .word_select(word_select),
    .serial_data_out(serial_data_out), .serial_data_in(serial_data_in));

  // Clocks between rising edges of master clock and word select; also the hang limit
  always @(posedge clock) begin
    mck_d <= master_clock_out;
    ws_d <= word_select;
    mck_cnt <= (master_clock_out && !mck_d) ? 1 : mck_cnt + 1;
    ws_cnt <= (word_select && !ws_d) ? 1 : ws_cnt + 1;
    if (master_clock_out && !mck_d) begin
      mck_per <= mck_cnt;
    end else if (psel && pwrite && paddr == OFF_CTRL) begin
      // A control write starts a fresh measurement
      mck_per <= 0;
    end
    if (word_select && !ws_d) begin
      ws_per <= ws_cnt;
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      finish_test();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One transfer; waits for ready, takes data at that edge, then releases
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Stop, program mode, clear flags; divider values are never zero
  task setup(input logic [5:0] r, d, input logic gen, rep, dma, mono, lp);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    apb(1'b1, OFF_MODE, {1'b0, gen, r, 2'b00, d, 1'b0, rep, dma, mono, 1'b0, lp, 10'h000});
    apb(1'b1, OFF_STATUS, 32'h0000_0007);
  endtask : setup

  task finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    // Mode reset value, ratio read back, divider hidden, unmapped place
    apb(1'b0, OFF_MODE, 32'h0000_0000);
    check(rd, 32'h0000_0000, "mode reset");
    apb(1'b1, OFF_MODE, 32'h3f3f_0000);
    apb(1'b0, OFF_MODE, 32'h0000_0000);
    check(rd, 32'h3f00_0000, "mode read back");
    apb(1'b0, 12'h020, 32'h0000_0000);
    check({rd_err, rd[30:0]}, 32'h8000_0000, "unmapped access");
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      setup(rt[i], dt[i], gt[i], 1'b0, 1'b0, 1'b0, 1'b0);
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      repeat (96 * (rt[i] + 1) + 40) @(posedge clock);
      check(mck_per, gt[i] ? dt[i] + 1 : 0, "master clock period");
      check(ws_per, 32 * (rt[i] + 1), "word select period");
    end
    $display("test clock ratios done");
    for (int i = 0; i < 4; i++) begin
      setup(6'h03, 6'h01, 1'b1, rp[i], dm[i], mo[i], 1'b0);
      apb(1'b1, OFF_TXLEFT, 32'h0000_a5c3);
      apb(1'b1, OFF_TXRIGHT, 32'h0000_1234);
      codec_clear <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      n = 0;
      while (i_codec.frames < 2 && n < 2000) begin
        @(posedge clock);
        n++;
      end
      lexp = rp[i] ? 16'ha5c3 : 16'h0000;
      check(i_codec.lw[0], 32'h0000_a5c3, "left first frame");
      check(i_codec.rw[0], mo[i] ? 32'h0000_a5c3 : 32'h0000_1234, "right first");
      check(i_codec.lw[1], lexp, "left underrun");
      check(i_codec.rw[1], mo[i] ? lexp : (rp[i] ? 16'h1234 : 16'h0000), "right under");
      check({tx_dma_req1, tx_dma_req0}, {dm[i] & !mo[i], 1'b1}, "dma requests");
      codec_clear <= 1'b1;
    end
    $display("test sample policies done");
    // Interrupt: sticky underrun, mask, clear
    apb(1'b1, OFF_MASK, 32'h0000_0000);
    repeat (2) @(negedge clock);
    check(irq, 1'b0, "irq while masked");
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    check(rd[0], 1'b1, "underrun flag");
    apb(1'b1, OFF_MASK, 32'h0000_0001);
    repeat (2) @(negedge clock);
    check(irq, 1'b1, "irq unmasked");
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    apb(1'b1, OFF_STATUS, 32'h0000_0001);
    repeat (2) @(negedge clock);
    check(irq, 1'b0, "irq cleared");
    $display("test interrupt done");
    // internal loop, then the line from the codec
    for (int i = 0; i < 2; i++) begin
      setup(6'h03, 6'h01, 1'b1, 1'b0, 1'b0, 1'b1, i == 0);
      apb(1'b1, OFF_TXLEFT, 32'h0000_c35a);
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      n = 0;
      rd = 32'h0000_0000;
      while (rd[1] !== 1'b1 && n < 100) begin
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        n++;
      end
      apb(1'b0, OFF_RXDATA, 32'h0000_0000);
      check(rd, i == 0 ? 32'h0000_c35a : 32'h0000_3ca5, "received word");
    end
    $display("test loopback done");
    finish_test();
  end
endmodule : i2s_mode_clock_and_tx_options_tb_top
